/* rtl/mirc_map.svh */
`ifndef MIRC_MAP_SVH
`define MIRC_MAP_SVH
// Minor cycle codes within a slice
`define MIRC_E0 4'h0
`define MIRC_E1 4'h1
`define MIRC_E7 4'h7
`define MIRC_E9 4'h9
`define MIRC_CS_WORD_W 14
`define MIRC_CS_WORDS 5120
`define MIRC_CS_ADDR_W 13
`define MIRC_PTR_W 14
`define MIRC_PTR_ONE 14'h0001
`define MIRC_CYC_W 4
`endif

/* rtl/mirc_pkg.sv */
`default_nettype none
package mirc_pkg;
    typedef enum logic [1:0] {
        MIRC_RUN,
        MIRC_BRANCH_IDLE,
        MIRC_RESYNC_IDLE
    } mirc_state_t;
endpackage
`default_nettype wire

/* rtl/mirc_idle_resync.sv */
// Function
// - Reset holds state-4 request cleared
// - Autoload sets state-4 request
// - Branch blocks register load one cycle
// - Idle flop sets next tick unless E7 or E9
// - Branch idle request held through E1
// - Partial jumps suppress pointer clock at E1
// - Idle flop self-clears one cycle later
// - Branch in E0..E6 takes two cycles
// - Branch at E7 takes one cycle
// - E7 branch forces register load at E0
// - Block released when slice first word loads
// - Resync ops block rest of slice
// - Resync block ignores idle flop, spans E0
// - Resync block overridden at next E0
// - Idle flop set one cycle after resync
// - Slice end clears idle flop
// - Control store holds 5120 14-bit words
`include "mirc_map.svh"
`default_nettype none
module mirc_idle_resync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [`MIRC_CYC_W-1:0] minor_cycle,
    input wire logic system_reset,
    input wire logic autoload,
    input wire logic partial_jump_op_f,
    input wire logic unconditional_jump_op,
    input wire logic clear_op,
    input wire logic store_a_op,
    input wire logic store_b_op,
    input wire logic and_to_pointer_op,
    input wire logic resync_jump_op,
    input wire logic next_instr_read_op_1,
    input wire logic next_instr_read_op_2,
    input wire logic channel_io_op_1,
    input wire logic channel_io_op_2,
    input wire logic rom_op,
    input wire logic sync_op,
    input wire logic zero_test_jump_op,
    input wire logic a_operand_zero,
    input wire logic [`MIRC_PTR_W-1:0] next_address,
    input wire logic cs_write,
    input wire logic [`MIRC_CS_ADDR_W-1:0] cs_addr,
    input wire logic [`MIRC_CS_WORD_W-1:0] cs_wdata,
    output logic [`MIRC_CS_WORD_W-1:0] cs_rdata,
    output logic [`MIRC_CS_WORD_W-1:0] uinstr_word,
    output logic [`MIRC_PTR_W-1:0] saved_pointer,
    output logic uinstr_load_block,
    output logic uinstr_reg_clock_enable,
    output logic saved_pointer_clock_enable,
    output logic idle_flag,
    output logic state4_request
);
    mirc_pkg::mirc_state_t state_reg;
    logic branch_op;
    logic resync_op;
    logic partial_op;
    logic at_e7;
    logic at_e0;
    logic at_end;
    logic idle_req_reg;
    logic partial_reg;
    logic [`MIRC_CS_WORD_W-1:0] cs_mem [`MIRC_CS_WORDS];

    // Branch ops in E0..E6 idle one cycle; E7 branches behave like blockpoints
    assign branch_op = partial_jump_op_f | unconditional_jump_op | clear_op |
                       store_a_op | store_b_op | and_to_pointer_op;
    assign partial_op = partial_jump_op_f | unconditional_jump_op;
    // Zero-test jump only resyncs when A is zero
    assign resync_op = resync_jump_op | next_instr_read_op_1 | next_instr_read_op_2 |
                       channel_io_op_1 | channel_io_op_2 | rom_op | sync_op |
                       (zero_test_jump_op & a_operand_zero);
    assign at_e7 = (minor_cycle == `MIRC_E7);
    assign at_e0 = (minor_cycle == `MIRC_E0);
    assign at_end = (minor_cycle == `MIRC_E9);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state4_request <= 1'b0;
        end else if (clk_en) begin
            if (system_reset) begin
                state4_request <= 1'b0;
            end else if (autoload) begin
                state4_request <= 1'b1;
            end
        end
    end

    // Sequencing state; resync decoded with priority over branch
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= mirc_pkg::MIRC_RUN;
            uinstr_load_block <= 1'b0;
            idle_flag <= 1'b0;
            idle_req_reg <= 1'b0;
            partial_reg <= 1'b0;
        end else if (clk_en) begin
            if (system_reset) begin
                state_reg <= mirc_pkg::MIRC_RUN;
                uinstr_load_block <= 1'b0;
                idle_flag <= 1'b0;
                idle_req_reg <= 1'b0;
                partial_reg <= 1'b0;
            end else begin
                case (state_reg)
                    mirc_pkg::MIRC_RUN: begin
                        idle_flag <= 1'b0;
                        idle_req_reg <= 1'b0;
                        partial_reg <= 1'b0;
                        uinstr_load_block <= 1'b0;
                        if (resync_op && !at_end) begin
                            state_reg <= mirc_pkg::MIRC_RESYNC_IDLE;
                            uinstr_load_block <= 1'b1;
                        end else if (branch_op && !at_e7 && !at_end) begin
                            // Discard sequential word fetched behind the branch
                            state_reg <= mirc_pkg::MIRC_BRANCH_IDLE;
                            uinstr_load_block <= 1'b1;
                            idle_req_reg <= 1'b1;
                            partial_reg <= partial_op;
                            idle_flag <= 1'b1;
                        end
                        // E7 branch needs no block: next slice E0 load
                    end
                    mirc_pkg::MIRC_BRANCH_IDLE: begin
                        // Flag feeds back to its own clear
                        idle_flag <= 1'b0;
                        uinstr_load_block <= 1'b0;
                        idle_req_reg <= 1'b0;
                        partial_reg <= 1'b0;
                        state_reg <= mirc_pkg::MIRC_RUN;
                    end
                    mirc_pkg::MIRC_RESYNC_IDLE: begin
                        idle_flag <= 1'b1;
                        if (at_end) begin
                            idle_flag <= 1'b0;
                        end
                        if (at_e0) begin
                            uinstr_load_block <= 1'b0;
                            idle_flag <= 1'b0;
                            state_reg <= mirc_pkg::MIRC_RUN;
                        end
                    end
                    default: begin
                        state_reg <= mirc_pkg::MIRC_RUN;
                    end
                endcase
            end
        end
    end

    // Slice-start override forces a load at E0 whatever the block says
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            uinstr_reg_clock_enable <= 1'b1;
        end else if (clk_en) begin
            uinstr_reg_clock_enable <= at_e0 | !uinstr_load_block;
        end
    end

    // Pointer clock off while idling in resync, and at E1 after partial jumps
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            saved_pointer_clock_enable <= 1'b1;
        end else if (clk_en) begin
            // Released on the slice-end edge so the next slice can update the pointer
            saved_pointer_clock_enable <= !((state_reg == mirc_pkg::MIRC_RESYNC_IDLE &&
                !at_end && !at_e0) ||
                (state_reg == mirc_pkg::MIRC_BRANCH_IDLE && partial_reg));
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            saved_pointer <= '0;
        end else if (clk_en && saved_pointer_clock_enable) begin
            saved_pointer <= next_address;
        end
    end

    // Flop storage; alterable from the panel write path
    always_ff @(posedge clk) begin
        if (clk_en && cs_write) begin
            cs_mem[cs_addr] <= cs_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_rdata <= '0;
        end else if (clk_en) begin
            cs_rdata <= cs_mem[cs_addr];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            uinstr_word <= '0;
        end else if (clk_en && uinstr_reg_clock_enable) begin
            uinstr_word <= cs_rdata;
        end
    end

    AST_RESET_REQ: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && system_reset) |=> !state4_request)
        else $error("state4 request set during reset");
    AST_AUTOLOAD: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !system_reset && autoload) |=> state4_request)
        else $error("autoload did not set state4 request");
    AST_BRANCH_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg == mirc_pkg::MIRC_RUN && !system_reset && !resync_op &&
         branch_op && !at_e7 && !at_end) ##1 clk_en[*2] |=>
        (uinstr_load_block && $past(uinstr_load_block, 2) == 1'b0) or !uinstr_load_block)
        else $error("branch block not one cycle");
    AST_BRANCH_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !system_reset && state_reg == mirc_pkg::MIRC_BRANCH_IDLE) |=> !idle_flag)
        else $error("idle flag not cleared");
    AST_E7_NOBLOCK: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg == mirc_pkg::MIRC_RUN && !system_reset && !resync_op &&
         branch_op && at_e7) |=> !uinstr_load_block)
        else $error("E7 branch blocked");
    AST_E0_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && at_e0) |=> uinstr_reg_clock_enable)
        else $error("no forced load at E0");
    AST_RESYNC_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !system_reset && state_reg == mirc_pkg::MIRC_RESYNC_IDLE && !at_e0)
        |=> uinstr_load_block)
        else $error("resync block dropped early");
    AST_RESYNC_PTR: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg == mirc_pkg::MIRC_RESYNC_IDLE && !at_end && !at_e0)
        |=> !saved_pointer_clock_enable)
        else $error("pointer clock during resync");
    AST_RESET_CLEAN: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && system_reset) |=> (!idle_flag && !uinstr_load_block))
        else $error("reset left idle state");
    // Clock enable low must freeze every piece of sequencing state
    AST_FREEZE_REQ: assert property (@(posedge clk) disable iff (!rst_n)
        (!clk_en) |=> $stable(state4_request))
        else $error("state4 request moved while frozen");
    AST_FREEZE_SEQ: assert property (@(posedge clk) disable iff (!rst_n)
        (!clk_en) |=> ($stable(uinstr_load_block) && $stable(idle_flag)))
        else $error("sequencing state moved while frozen");
    AST_BRANCH_IDLE_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg == mirc_pkg::MIRC_RUN && !system_reset && !resync_op &&
         branch_op && !at_e7 && !at_end) |=> idle_flag)
        else $error("branch did not set idle flag");
    AST_BRANCH_TWO: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg == mirc_pkg::MIRC_RUN && !system_reset && !resync_op &&
         branch_op && !at_e7 && !at_end) ##1 (clk_en && !system_reset) |=> !uinstr_load_block)
        else $error("branch took more than two cycles");
    AST_PARTIAL_PTR: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg == mirc_pkg::MIRC_BRANCH_IDLE && partial_reg)
        |=> !saved_pointer_clock_enable)
        else $error("pointer clocked after partial jump");
    AST_PTR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !saved_pointer_clock_enable) |=> $stable(saved_pointer))
        else $error("pointer changed while its clock was off");
    AST_E7_NO_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg == mirc_pkg::MIRC_RUN && !system_reset && !resync_op &&
         branch_op && at_e7) |=> !idle_flag)
        else $error("E7 branch idled");
    AST_BLOCK_NO_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !at_e0 && uinstr_load_block) |=> !uinstr_reg_clock_enable)
        else $error("register loaded while blocked");
    AST_RESYNC_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg == mirc_pkg::MIRC_RUN && !system_reset && resync_op && !at_end)
        |=> uinstr_load_block)
        else $error("resync did not block");
    AST_IDLE_LATE: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && state_reg == mirc_pkg::MIRC_RUN && !system_reset && resync_op && !at_end)
        |=> !idle_flag)
        else $error("resync idle flag set too early");
    AST_RESYNC_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !system_reset && state_reg == mirc_pkg::MIRC_RESYNC_IDLE && at_e0)
        |=> !uinstr_load_block)
        else $error("resync block not released at E0");
    AST_RESYNC_FORCE: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !system_reset && state_reg == mirc_pkg::MIRC_RESYNC_IDLE && at_e0)
        |=> uinstr_reg_clock_enable)
        else $error("resync load not forced at E0");
    AST_SLICE_END: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_en && !system_reset && state_reg == mirc_pkg::MIRC_RESYNC_IDLE && at_end)
        |=> (!idle_flag && saved_pointer_clock_enable))
        else $error("slice end did not release idle");

    COV_BRANCH: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == mirc_pkg::MIRC_BRANCH_IDLE);
    COV_RESYNC: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == mirc_pkg::MIRC_RESYNC_IDLE ##1 state_reg == mirc_pkg::MIRC_RUN);
    COV_AUTOLOAD: cover property (@(posedge clk) disable iff (!rst_n) state4_request);
    COV_E7_BRANCH: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == mirc_pkg::MIRC_RUN && branch_op && at_e7);
    COV_PARTIAL: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == mirc_pkg::MIRC_BRANCH_IDLE && partial_reg);
endmodule
`default_nettype wire

/* test/mirc_decode_model.sv */
`default_nettype none
module mirc_decode_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] op_sel,
    input wire logic op_valid,
    output logic [3:0] minor_cycle,
    output logic [13:0] ops
);
    timeunit 1ns;
    timeprecision 1ns;
    // Ten minor cycles per slice, as a forced consecutive count gives
    always_ff @(posedge clk) begin
        if (!rst_n || minor_cycle == 4'h9) begin
            minor_cycle <= 4'h0;
        end else begin
            minor_cycle <= minor_cycle + 4'h1;
        end
    end
    // One decode line high, only in its execute cycle
    assign ops = op_valid ? (14'h0001 << op_sel) : 14'h0000;
endmodule
`default_nettype wire

/* test/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic system_reset = 1'b0;
    logic autoload = 1'b0;
    logic a_zero = 1'b0;
    logic cs_write = 1'b0;
    logic [12:0] cs_addr = 13'h0000;
    logic [13:0] cs_wdata = 14'h0000;
    logic [13:0] next_address = 14'h1234;
    logic [3:0] op_sel = 4'h0;
    logic op_valid = 1'b0;
    logic [3:0] mc;
    logic [13:0] ops, cs_rdata, word, ptr;
    logic blk, fm_en, pp_en, idle, req4;
    int err_total = 0;
    int samples_checked = 0;
    mirc_decode_model model (.clk(clk), .rst_n(rst_n), .op_sel(op_sel), .op_valid(op_valid),
        .minor_cycle(mc), .ops(ops));
    mirc_idle_resync dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .minor_cycle(mc),
        .system_reset(system_reset), .autoload(autoload), .partial_jump_op_f(ops[0]),
        .unconditional_jump_op(ops[1]), .clear_op(ops[2]), .store_a_op(ops[3]),
        .store_b_op(ops[4]), .and_to_pointer_op(ops[5]), .resync_jump_op(ops[6]),
        .next_instr_read_op_1(ops[7]), .next_instr_read_op_2(ops[8]),
        .channel_io_op_1(ops[9]), .channel_io_op_2(ops[10]), .rom_op(ops[11]),
        .sync_op(ops[12]), .zero_test_jump_op(ops[13]), .a_operand_zero(a_zero),
        .next_address(next_address), .cs_write(cs_write), .cs_addr(cs_addr),
        .cs_wdata(cs_wdata), .cs_rdata(cs_rdata), .uinstr_word(word), .saved_pointer(ptr),
        .uinstr_load_block(blk), .uinstr_reg_clock_enable(fm_en),
        .saved_pointer_clock_enable(pp_en), .idle_flag(idle), .state4_request(req4));
    task automatic summarize();
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic nxt();
        @(posedge clk);
        #1;
    endtask
    // Decode shows during cycle c, taken at its closing edge
    task automatic exec(input logic [3:0] op, input logic [3:0] c);
        nxt();
        while (mc != ((c == 4'h0) ? 4'h9 : c - 4'h1)) nxt();
        @(posedge clk);
        op_sel <= op;
        op_valid <= 1'b1;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
    endtask
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({blk, idle, fm_en, pp_en, req4}, 14'h0006);
        for (int i = 0; i < 6; i++) begin
            exec(i[3:0], 4'h2);
            chk({blk, idle}, 14'h0003);
            nxt();
            chk({blk, idle, fm_en, pp_en}, {13'h0000, i > 1});
            nxt();
            chk({fm_en, pp_en}, 14'h0003);
        end
        exec(4'h0, 4'h7);
        chk({blk, fm_en}, 14'h0001);
        @(posedge clk);
        a_zero <= 1'b1;
        for (int i = 6; i < 14; i++) begin
            exec(i[3:0], 4'h3);
            chk(blk, 1'b1);
            nxt();
            chk({idle, pp_en}, 14'h0002);
            while (mc != 4'h0) nxt();
            chk({blk, idle}, 14'h0002);
            nxt();
            chk({blk, fm_en, pp_en}, 14'h0003);
        end
        @(posedge clk);
        a_zero <= 1'b0;
        exec(4'hD, 4'h3);
        chk(blk, 1'b0);
        chk(ptr, 14'h1234);
        @(posedge clk);
        autoload <= 1'b1;
        nxt();
        chk(req4, 1'b1);
        @(posedge clk);
        system_reset <= 1'b1;
        nxt();
        chk({req4, blk, idle}, 14'h0000);
        @(posedge clk);
        system_reset <= 1'b0;
        autoload <= 1'b0;
        cs_write <= 1'b1;
        cs_addr <= 13'h13FF;
        cs_wdata <= 14'h2A5C;
        @(posedge clk);
        cs_write <= 1'b0;
        nxt();
        chk(cs_rdata, 14'h2A5C);
        nxt();
        chk(word, 14'h2A5C);
        @(posedge clk);
        clk_en <= 1'b0;
        autoload <= 1'b1;
        nxt();
        nxt();
        chk(req4, 1'b0);
        @(posedge clk);
        clk_en <= 1'b1;
        nxt();
        chk(req4, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
